//--- adc_post_pkg.sv
// constants, register map and types for the converter post-processing block
package adc_post_pkg;
    // register byte offsets
    localparam logic [7:0]  OFF_CONV_AVG   = 8'h24;
    localparam logic [7:0]  OFF_OFFSET     = 8'h28;
    localparam logic [7:0]  OFF_PLUS_GAIN  = 8'h2C;
    localparam logic [7:0]  OFF_MINUS_GAIN = 8'h30;
    localparam logic [7:0]  OFF_CTRL       = 8'h20;
    localparam logic [7:0]  OFF_RESULT     = 8'h1C;
    // conv_average_control fields
    localparam int          BIT_CONT       = 3;
    localparam int          BIT_AVGEN      = 2;
    localparam int          BIT_AVERAGE_COUNT_SEL_HI    = 1;
    localparam int          BIT_AVERAGE_COUNT_SEL_LO    = 0;
    // own control register: bit 0 start, bit 1 differential, bit 2 busy (read)
    localparam int          BIT_START      = 0;
    localparam int          BIT_DIFF       = 1;
    localparam int          BIT_BUSY       = 2;
    // reset values
    localparam logic [3:0]  RST_CONV_AVG   = 4'h0;
    localparam logic [15:0] RST_OFFSET     = 16'h0000;
    localparam logic [15:0] RST_GAIN       = 16'h8000;
    localparam logic        RST_DIFF       = 1'b0;
    // widths and limits
    localparam int          SW             = 16;
    localparam int          ACCW           = 21;
    localparam int          GAIN_FRAC      = 15;
    localparam logic [4:0]  CNT_ZERO       = 5'h00;
    localparam logic [4:0]  CNT_ONE        = 5'h01;
    localparam logic [15:0] SE_MAX         = 16'hFFFF;
    localparam logic [15:0] SE_MIN         = 16'h0000;
    localparam logic [15:0] DF_MAX         = 16'h7FFF;
    localparam logic [15:0] DF_MIN         = 16'h8000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_CALC
    } seq_t;
endpackage : adc_post_pkg

//--- sample_sync.sv
// two-stage synchroniser for the raw sample strobe and data from the analog core
module sample_sync (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // analog side
    input  wire logic        rawValid,
    input  wire logic [15:0] rawPlus,
    input  wire logic [15:0] rawMinus,
    // clocked side
    output logic             syncValid,
    output logic      [15:0] syncPlus,
    output logic      [15:0] syncMinus
);
    import adc_post_pkg::*;

    logic        vMeta_ff;
    logic        vSync_ff;
    logic        vPrev_ff;
    logic [15:0] pMeta_ff;
    logic [15:0] pSync_ff;
    logic [15:0] mMeta_ff;
    logic [15:0] mSync_ff;
    logic        nxt_syncValid;

    always_comb begin
        nxt_syncValid = vSync_ff & ~vPrev_ff;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vMeta_ff  <= 1'b0;
            vSync_ff  <= 1'b0;
            vPrev_ff  <= 1'b0;
            pMeta_ff  <= 16'h0000;
            pSync_ff  <= 16'h0000;
            mMeta_ff  <= 16'h0000;
            mSync_ff  <= 16'h0000;
            syncValid <= 1'b0;
            syncPlus  <= 16'h0000;
            syncMinus <= 16'h0000;
        end else begin
            vMeta_ff  <= rawValid;
            vSync_ff  <= vMeta_ff;
            vPrev_ff  <= vSync_ff;
            pMeta_ff  <= rawPlus;
            pSync_ff  <= pMeta_ff;
            mMeta_ff  <= rawMinus;
            mSync_ff  <= mMeta_ff;
            syncValid <= nxt_syncValid;
            syncPlus  <= pSync_ff;
            syncMinus <= mSync_ff;
        end
    end
endmodule : sample_sync

//--- adc_average_offset_gain_ctrl.sv
// converter sequencing, averaging, offset and gain correction with Avalon-MM registers
// Overview of operation
// - continuous clear: one conversion or one averaged set per start, then stop.
// - continuous set: conversions or averaged sets repeat after a start.
// - averaging enable bit turns hardware averaging on or off.
// - average select 00,01,10,11 gives 4,8,16,32 samples per result.
// - offset value subtracted from each conversion before storing the result.
// - corrected value clamped to the mode's maximum or minimum.
// - offset is signed two's complement, left-justified, sixteen bits.
// - plus gain is unsigned fixed point, binary point between bits 15 and 14.
// - plus gain scales plus input in differential, whole conversion single-ended.
// - minus gain scales only the minus input, ignored single-ended.
// - minus gain is sixteen-bit fixed point, point below its top bit.
// - offset and gain upper bits 31 to 16 read zero, ignore writes.
//
// The Avalon-MM register port is this design's own decision.
module adc_average_offset_gain_ctrl (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // analog core
    input  wire logic        sampleValid,
    input  wire logic [15:0] samplePlus,
    input  wire logic [15:0] sampleMinus,
    output logic             convStart,
    output logic             diffMode,
    // corrected result
    output logic      [15:0] resultRegs,
    output logic             resultValid
);
    import adc_post_pkg::*;

    logic        sValid;
    logic [15:0] sPlus;
    logic [15:0] sMinus;

    sample_sync u_sync (
        .clk       (clk),
        .nrst      (nrst),
        .rawValid  (sampleValid),
        .rawPlus   (samplePlus),
        .rawMinus  (sampleMinus),
        .syncValid (sValid),
        .syncPlus  (sPlus),
        .syncMinus (sMinus)
    );

    // register state
    logic [3:0]  convAvg_ff,   nxt_convAvg;
    logic [15:0] offset_ff,    nxt_offset;
    logic [15:0] plusGain_ff,  nxt_plusGain;
    logic [15:0] minusGain_ff, nxt_minusGain;
    logic        diff_ff,      nxt_diff;
    logic        startReq;
    logic        ack_ff,       nxt_ack;
    logic        waitReq_ff,   nxt_waitReq;
    logic [31:0] rd_ff,        nxt_rd;

    // sequencer state
    seq_t        state_ff,     nxt_state;
    logic [4:0]  cnt_ff,       nxt_cnt;
    logic [ACCW-1:0] acc_ff,   nxt_acc;
    logic        start_ff,     nxt_start;
    logic [15:0] res_ff,       nxt_res;
    logic        resV_ff,      nxt_resV;

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        lane16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : lane16

    function automatic logic [15:0] gainMul(input logic [15:0] x, input logic [15:0] g);
        logic [31:0] p;
        logic [16:0] q;
        p = x * g;
        q = p[31:GAIN_FRAC];
        gainMul = q[16] ? SE_MAX : q[15:0];
    endfunction : gainMul

    function automatic logic [4:0] setSize(input logic [1:0] sel);
        unique case (sel)
            2'b00: setSize = 5'h03;
            2'b01: setSize = 5'h07;
            2'b10: setSize = 5'h0F;
            2'b11: setSize = 5'h1F;
        endcase
    endfunction : setSize

    // bus: one wait cycle then answer
    always_comb begin
        nxt_convAvg   = convAvg_ff;
        nxt_offset    = offset_ff;
        nxt_plusGain  = plusGain_ff;
        nxt_minusGain = minusGain_ff;
        nxt_diff      = diff_ff;
        startReq      = 1'b0;
        nxt_ack       = (read | write) & ~ack_ff;
        nxt_waitReq   = ~nxt_ack;
        nxt_rd        = rd_ff;
        if (write && ack_ff) begin
            unique case (address)
                OFF_CONV_AVG:   if (byteenable[0]) nxt_convAvg = writedata[3:0];
                OFF_OFFSET:     nxt_offset    = lane16(offset_ff, writedata, byteenable);
                OFF_PLUS_GAIN:  nxt_plusGain  = lane16(plusGain_ff, writedata, byteenable);
                OFF_MINUS_GAIN: nxt_minusGain = lane16(minusGain_ff, writedata, byteenable);
                OFF_CTRL: begin
                    if (byteenable[0]) begin
                        nxt_diff = writedata[BIT_DIFF];
                        startReq = writedata[BIT_START];
                    end
                end
                default: ;
            endcase
        end
        if (read && !ack_ff) begin
            unique case (address)
                OFF_CONV_AVG:   nxt_rd = {28'h0000000, convAvg_ff};
                OFF_OFFSET:     nxt_rd = {16'h0000, offset_ff};
                OFF_PLUS_GAIN:  nxt_rd = {16'h0000, plusGain_ff};
                OFF_MINUS_GAIN: nxt_rd = {16'h0000, minusGain_ff};
                OFF_CTRL:       nxt_rd = {29'h00000000, state_ff != ST_IDLE, diff_ff, 1'b0};
                OFF_RESULT:     nxt_rd = {16'h0000, res_ff};
                default:        nxt_rd = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            convAvg_ff   <= RST_CONV_AVG;
            offset_ff    <= RST_OFFSET;
            plusGain_ff  <= RST_GAIN;
            minusGain_ff <= RST_GAIN;
            diff_ff      <= RST_DIFF;
            ack_ff       <= 1'b0;
            waitReq_ff   <= 1'b1;
            rd_ff        <= 32'h00000000;
        end else begin
            convAvg_ff   <= nxt_convAvg;
            offset_ff    <= nxt_offset;
            plusGain_ff  <= nxt_plusGain;
            minusGain_ff <= nxt_minusGain;
            diff_ff      <= nxt_diff;
            ack_ff       <= nxt_ack;
            waitReq_ff   <= nxt_waitReq;
            rd_ff        <= nxt_rd;
        end
    end

    // held high while idle, low in the answering cycle
    assign waitrequest = waitReq_ff;
    assign readdata    = rd_ff;

    // correction datapath
    logic [15:0] rawSum;
    logic [15:0] gained;
    logic signed [17:0] corr;
    logic [15:0] clamped;
    logic [ACCW-1:0] accIn;
    logic [ACCW-1:0] mean;
    logic        avgOn;
    logic        lastOne;

    always_comb begin
        avgOn = convAvg_ff[BIT_AVGEN];
        lastOne = !avgOn || (cnt_ff == setSize(convAvg_ff[BIT_AVERAGE_COUNT_SEL_HI:BIT_AVERAGE_COUNT_SEL_LO]));
        if (diff_ff) begin
            gained = 16'(({1'b0, gainMul(sPlus, plusGain_ff)} - {1'b0, gainMul(sMinus, minusGain_ff)}) >>> 1);
            rawSum = gained;
        end else begin
            gained = gainMul(sPlus, plusGain_ff);
            rawSum = gained;
        end
        // differential samples are signed and must sign-extend into the sum
        accIn = acc_ff + {{(ACCW - SW){diff_ff & rawSum[SW-1]}}, rawSum};
        unique case (convAvg_ff[BIT_AVERAGE_COUNT_SEL_HI:BIT_AVERAGE_COUNT_SEL_LO])
            2'b00: mean = accIn >> 2;
            2'b01: mean = accIn >> 3;
            2'b10: mean = accIn >> 4;
            2'b11: mean = accIn >> 5;
        endcase
        if (!avgOn) mean = ACCW'(rawSum);
        if (diff_ff) corr = 18'(signed'(mean[15:0])) - 18'(signed'(offset_ff));
        else         corr = 18'(signed'({1'b0, mean[15:0]})) - 18'(signed'(offset_ff));
        if (diff_ff) begin
            if (corr > 18'sd32767)       clamped = DF_MAX;
            else if (corr < -18'sd32768) clamped = DF_MIN;
            else                          clamped = corr[15:0];
        end else begin
            if (corr > 18'sd65535)       clamped = SE_MAX;
            else if (corr < 18'sd0)      clamped = SE_MIN;
            else                          clamped = corr[15:0];
        end
    end

    // sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_acc   = acc_ff;
        nxt_start = 1'b0;
        nxt_res   = res_ff;
        nxt_resV  = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (startReq) begin
                    nxt_state = ST_WAIT;
                    nxt_start = 1'b1;
                    nxt_cnt   = CNT_ZERO;
                    nxt_acc   = '0;
                end
            end
            ST_WAIT: begin
                if (sValid) begin
                    if (lastOne) begin
                        nxt_res  = clamped;
                        nxt_resV = 1'b1;
                        nxt_cnt  = CNT_ZERO;
                        nxt_acc  = '0;
                        if (convAvg_ff[BIT_CONT]) begin
                            nxt_start = 1'b1;
                        end else begin
                            nxt_state = ST_IDLE;
                        end
                    end else begin
                        nxt_acc   = accIn;
                        nxt_cnt   = cnt_ff + CNT_ONE;
                        nxt_start = 1'b1;
                    end
                end
            end
            ST_CALC: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= CNT_ZERO;
            acc_ff   <= '0;
            start_ff <= 1'b0;
            res_ff   <= 16'h0000;
            resV_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            acc_ff   <= nxt_acc;
            start_ff <= nxt_start;
            res_ff   <= nxt_res;
            resV_ff  <= nxt_resV;
        end
    end

    assign convStart   = start_ff;
    assign diffMode    = diff_ff;
    assign resultRegs  = res_ff;
    assign resultValid = resV_ff;

    // checks
    chk_single_stops: assert property (@(posedge clk) disable iff (!nrst)
        (resV_ff && !convAvg_ff[BIT_CONT] && $past(!convAvg_ff[BIT_CONT])) |-> state_ff == ST_IDLE)
        else $error("single mode did not stop after result");
    chk_cont_restarts: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_WAIT && sValid && lastOne && convAvg_ff[BIT_CONT]) |=> start_ff && state_ff == ST_WAIT)
        else $error("continuous mode did not restart");
    chk_avg_off_each: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_WAIT && sValid && !convAvg_ff[BIT_AVGEN]) |=> resV_ff)
        else $error("unaveraged sample gave no result");
    chk_avg_count: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_WAIT && sValid && convAvg_ff[BIT_AVGEN] && cnt_ff == CNT_ZERO) |=> !resV_ff)
        else $error("averaged set ended after one sample");
    chk_single_clamp: assert property (@(posedge clk) disable iff (!nrst)
        (!diff_ff && corr < 18'sd0) |-> clamped == SE_MIN)
        else $error("negative single-ended value not clamped");
    chk_diff_clamp: assert property (@(posedge clk) disable iff (!nrst)
        (diff_ff && corr > 18'sd32767) |-> clamped == DF_MAX)
        else $error("differential value not clamped");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        (ack_ff && read && address == OFF_OFFSET) |-> rd_ff[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");
    chk_result_latch: assert property (@(posedge clk) disable iff (!nrst)
        resV_ff |-> res_ff == $past(clamped))
        else $error("result not the corrected value");
    sequence startWrite;
        write && ack_ff && address == OFF_CTRL && byteenable[0] && writedata[BIT_START] && state_ff == ST_IDLE;
    endsequence
    sequence convIssued;
        start_ff && state_ff == ST_WAIT;
    endsequence
    chk_start_issue: assert property (@(posedge clk) disable iff (!nrst)
        startWrite |=> convIssued)
        else $error("start write issued no conversion");
endmodule : adc_average_offset_gain_ctrl

//--- analog_core_model.sv
// analog core model: answers every conversion request with one held sample
module analog_core_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // requests and settings
    input  wire logic        convStart,
    input  wire logic        slow,
    input  wire logic [15:0] plusBase,
    input  wire logic [15:0] minusBase,
    // sample side
    output logic             sampleValid,
    output logic      [15:0] samplePlus,
    output logic      [15:0] sampleMinus
);
    timeunit 1ns;
    timeprecision 1ps;
    int reqCnt;
    int srvCnt;
    // requests may arrive while a sample is still held, so they queue as a count
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reqCnt <= 0;
        end else if (convStart === 1'b1) begin
            reqCnt <= reqCnt + 1;
        end
    end
    initial begin
        srvCnt = 0;
        sampleValid = 1'b0;
        samplePlus = 16'h5A5A;
        sampleMinus = 16'hA5A5;
        forever begin
            @(posedge clk);
            if (reqCnt > srvCnt) begin
                repeat (slow ? 9 : 2) @(posedge clk);
                samplePlus <= plusBase + 16'(srvCnt);
                sampleMinus <= minusBase;
                repeat (4) @(posedge clk);
                sampleValid <= 1'b1;
                repeat (4) @(posedge clk);
                sampleValid <= 1'b0;
                repeat (4) @(posedge clk);
                // past the hold time the lines no longer carry the sample
                samplePlus <= ~samplePlus;
                sampleMinus <= ~sampleMinus;
                srvCnt++;
            end
        end
    end
endmodule : analog_core_model

//--- tb_top.sv
// testbench: register access, single, averaged and continuous conversions
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_post_pkg::*;
    logic        clk;
    logic        nrst;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sampleValid;
    logic [15:0] samplePlus;
    logic [15:0] sampleMinus;
    logic        convStart;
    logic        diffMode;
    logic [15:0] resultRegs;
    logic        resultValid;
    logic        slow;
    logic [15:0] plusBase;
    logic [15:0] minusBase;
    int          err_total;
    int          n_tests;
    int          convCnt = 0;
    int          cyc = 0;
    logic [15:0] tP[8]   = '{16'h1000, 16'hFFE0, 16'h0010, 16'h2000, 16'h4000, 16'h3000, 16'hFFE0, 16'h0000};
    logic [15:0] tM[8]   = '{16'h0000, 16'h0000, 16'h0000, 16'h1234, 16'h0000, 16'h2000, 16'h0000, 16'h8000};
    logic [15:0] tGp[8]  = '{16'h8000, 16'h8000, 16'h8000, 16'h4000, 16'hFFFF, 16'h8000, 16'hFFFF, 16'h8000};
    logic [15:0] tGm[8]  = '{16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h8000, 16'h4000, 16'h8000, 16'h8000};
    logic [15:0] tOfs[8] = '{16'h0010, 16'hFFC0, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'hFFC0, 16'h7000};
    logic        tDf[8]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    adc_average_offset_gain_ctrl uut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .sampleValid(sampleValid), .samplePlus(samplePlus), .sampleMinus(sampleMinus), .convStart(convStart),
        .diffMode(diffMode), .resultRegs(resultRegs), .resultValid(resultValid));
    analog_core_model core (.clk(clk), .nrst(nrst), .convStart(convStart), .slow(slow), .plusBase(plusBase),
        .minusBase(minusBase), .sampleValid(sampleValid), .samplePlus(samplePlus), .sampleMinus(sampleMinus));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convStart === 1'b1) begin
            convCnt <= convCnt + 1;
        end
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one access: held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) err_total++;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : chk

    task automatic wait_res(output logic [15:0] r);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (resultValid !== 1'b1 && n < 2000);
        r = resultRegs;
        if (n >= 2000) err_total++;
    endtask : wait_res

    // start, compare the result, then count the conversions that were requested
    task automatic conv(input logic df, input int n, input logic [15:0] e);
        int c0;
        logic [15:0] r;
        c0 = convCnt;
        wr(OFF_CTRL, {30'h0, df, 1'b1});
        wait_res(r);
        check({16'h0, r}, {16'h0, e});
        repeat (60) @(posedge clk);
        check(32'(convCnt - c0), 32'(n));
        check({31'h0, diffMode}, {31'h0, df});
    endtask : conv

    function automatic logic [15:0] calc(input logic [15:0] p, m, gp, gm, ofs, input logic df);
        longint a;
        longint b;
        longint r;
        a = (longint'(p) * longint'(gp)) >>> 15;
        b = (longint'(m) * longint'(gm)) >>> 15;
        if (a > 65535) a = 65535;
        if (b > 65535) b = 65535;
        r = df ? (a - b) >>> 1 : a;
        r = r - longint'($signed(ofs));
        if (df) r = (r > 32767) ? 32767 : ((r < -32768) ? -32768 : r);
        else r = (r > 65535) ? 65535 : ((r < 0) ? 0 : r);
        return r[15:0];
    endfunction : calc

    initial begin
        logic [15:0] r;
        int c0;
        longint s;
        nrst = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        slow = 1'b0;
        plusBase = 16'h0000;
        minusBase = 16'h0000;
        err_total = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        chk(OFF_CONV_AVG, {28'h0, RST_CONV_AVG});
        chk(OFF_OFFSET, {16'h0, RST_OFFSET});
        chk(OFF_PLUS_GAIN, {16'h0, RST_GAIN});
        chk(OFF_MINUS_GAIN, {16'h0, RST_GAIN});
        wr(OFF_OFFSET, 32'hFFFFFFFF);
        chk(OFF_OFFSET, 32'h0000FFFF);
        wr(OFF_PLUS_GAIN, 32'hFFFFFFFF);
        chk(OFF_PLUS_GAIN, 32'h0000FFFF);
        wr(OFF_MINUS_GAIN, 32'hFFFFFFFF);
        chk(OFF_MINUS_GAIN, 32'h0000FFFF);
        wr(8'h40, 32'h12345678);
        chk(8'h40, 32'h0);
        // averaging off although the largest count is selected
        wr(OFF_CONV_AVG, 32'hFFFFFFF3);
        chk(OFF_CONV_AVG, 32'h00000003);
        for (int i = 0; i < 8; i++) begin
            wr(OFF_PLUS_GAIN, {16'h0, tGp[i]});
            wr(OFF_MINUS_GAIN, {16'h0, tGm[i]});
            wr(OFF_OFFSET, {16'h0, tOfs[i]});
            plusBase <= tP[i];
            minusBase <= tM[i];
            @(posedge clk);
            conv(tDf[i], 1, calc(tP[i] + 16'(convCnt), tM[i], tGp[i], tGm[i], tOfs[i], tDf[i]));
        end
        wr(OFF_PLUS_GAIN, 32'h8000);
        wr(OFF_MINUS_GAIN, 32'h8000);
        wr(OFF_OFFSET, 32'h0);
        plusBase <= 16'h0100;
        for (int c = 0; c < 4; c++) begin
            slow <= c[0];
            wr(OFF_CONV_AVG, 32'h4 | 32'(c));
            conv(1'b0, 4 << c, 16'h0100 + 16'(convCnt) + 16'((4 << c) / 2 - 1));
        end
        // differential set whose samples straddle zero
        wr(OFF_CONV_AVG, 32'h4);
        minusBase <= 16'h0101 + 16'(convCnt);
        s = 0;
        for (int j = 0; j < 4; j++) begin
            s += longint'($signed(calc(16'h0100 + 16'(convCnt + j), 16'h0101 + 16'(convCnt),
                16'h8000, 16'h8000, 16'h0000, 1'b1)));
        end
        conv(1'b1, 4, 16'(s >>> 2));
        wr(OFF_CONV_AVG, 32'h8);
        c0 = convCnt;
        wr(OFF_CTRL, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wait_res(r);
            check({16'h0, r}, {16'h0, 16'h0100 + 16'(c0 + k)});
        end
        wr(OFF_CONV_AVG, 32'h0);
        repeat (150) @(posedge clk);
        c0 = convCnt;
        repeat (100) @(posedge clk);
        check(32'(convCnt - c0), 32'h0);
        wrap_up();
    end
endmodule : tb_top
